// >>> pkg/wpm_pkg.sv
// constants for the wake pattern match store and its matcher
package wpm_pkg;
  // ************************************************************
  // store geometry
  // ************************************************************
  localparam int STORE_DEPTH = 64;
  localparam int STORE_WIDTH = 40;
  localparam int INDEX_WIDTH = 7;
  localparam int PATTERNS = 8;
  // ************************************************************
  // port register layout
  // ************************************************************
  localparam int LOW_INDEX_MSB = 6;
  localparam int LOW_DATA_LSB = 8;
  localparam int LOW_DATA_MSB = 31;
  localparam int HIGH_DATA_MSB = 15;
  localparam int ENTRY_LOW_MSB = 23;
  localparam int ENTRY_HIGH_LSB = 24;
  localparam int ENTRY_HIGH_MSB = 39;
  // ************************************************************
  // special entries and control field
  // ************************************************************
  localparam logic [5:0] ENTRY_PTR_LO = 6'h00;
  localparam logic [5:0] ENTRY_PTR_HI = 6'h01;
  localparam int CTL_LAST_BIT = 7;
  localparam int CTL_SKIP_LSB = 4;
  localparam int CTL_SKIP_MSB = 6;
  localparam int CTL_MASK_MSB = 3;
  // ************************************************************
  // wake control and status bit positions
  // ************************************************************
  localparam int CMD_WAKE_BIT = 3;
  localparam int HIT_FLAG_BIT = 12;
  localparam int WAKE_STATUS_BIT = 15;
  localparam int PIN_ENABLE_BIT = 8;
  // ************************************************************
  // legacy ports select
  // ************************************************************
  localparam logic [1:0] LEG_A = 2'h0;
  localparam logic [1:0] LEG_B = 2'h1;
  localparam logic [1:0] LEG_C = 2'h2;
endpackage : wpm_pkg

// >>> verilog/wpm_matcher.sv
// walks one pattern through the store against incoming frame dwords
`timescale 1ns/1ns
module wpm_matcher
  import wpm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic [7:0] enables,
  input wire logic [63:0] starts,
  // store read port
  output logic [5:0] rd_addr,
  input wire logic [39:0] rd_data,
  // frame stream
  input wire logic frame_start,
  input wire logic frame_valid,
  input wire logic [31:0] frame_dword,
  // result
  output logic hit
);
  typedef enum logic [1:0] {
    WPM_IDLE = 2'b00,
    WPM_SKIP = 2'b01,
    WPM_CMP = 2'b10,
    WPM_DONE = 2'b11
  } wpm_state_t;

  wpm_state_t state;
  logic [2:0] pat;
  logic [2:0] skip_left;
  logic ok;

  function automatic logic bytes_equal(input logic [39:0] e, input logic [31:0] d);
    logic r;
    r = 1'b1;
    for (int n = 0; n < 4; n++) begin
      if (e[n] && (e[8*n+8 +: 8] != d[8*n +: 8])) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction : bytes_equal

  // one pattern per frame, rotating; a trade of speed for area
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= WPM_IDLE;
      pat <= 3'h0;
      rd_addr <= 6'h00;
      skip_left <= 3'h0;
      ok <= 1'b0;
      hit <= 1'b0;
    end else begin
      hit <= 1'b0;
      if (!run) begin
        state <= WPM_IDLE;
      end else if (frame_start) begin
        rd_addr <= starts[8*pat +: 6]; // RULE16
        ok <= enables[pat]; // RULE7
        state <= WPM_SKIP;
      end else begin
        unique case (state)
          WPM_IDLE: state <= WPM_IDLE;
          // a dword arriving while the next skip count loads is not compared
          WPM_SKIP: begin
            skip_left <= rd_data[CTL_SKIP_MSB:CTL_SKIP_LSB]; // RULE10
            state <= WPM_CMP;
          end
          WPM_CMP: if (frame_valid) begin
            if (skip_left != 3'h0) begin
              skip_left <= skip_left - 3'h1;
            end else begin
              if (!bytes_equal(rd_data, frame_dword)) begin // RULE11
                ok <= 1'b0;
              end
              if (rd_data[CTL_LAST_BIT]) begin // RULE9
                hit <= ok && bytes_equal(rd_data, frame_dword); // RULE16
                state <= WPM_DONE;
                pat <= pat + 3'h1;
              end else begin
                rd_addr <= rd_addr + 6'h01;
                state <= WPM_SKIP;
              end
            end
          end
          WPM_DONE: state <= WPM_DONE;
        endcase
      end
    end
  end

  property p_hit_needs_enable;
    @(posedge clk) disable iff (!rst_b) hit |-> $past(ok);
  endproperty
  a_hit_needs_enable: assert property (p_hit_needs_enable) else $error("hit without enable"); // RULE7
endmodule : wpm_matcher

// >>> verilog/wpm_store.sv
// pattern store with indirect port access, legacy ports and wake status
`timescale 1ns/1ns
// What this block does
// RULE1: a 64 by 40 bit store reached only through indirect ports
// RULE2: software disables pattern wake before touching the store
// RULE3: low port write gives index in 6:0 and low data in 31:8
// RULE4: the store write happens on the high port write, bits 15:0 to 39:24
// RULE5: read begins with index write; other bits of that write are ignored
// RULE6: low read returns 23:0 at 31:8, high read 39:24 at 15:0, any order
// RULE7: byte 0 of entry 0 enables patterns one bit each
// RULE8: entries 0 and 1 bytes 1 to 4 hold pattern start pointers
// RULE9: control bit 7 marks the last word of a pattern
// RULE10: control bits 6-4 count dwords skipped before comparing
// RULE11: control bits 3-0 mask data bytes out of the comparison
// RULE12: no reset touches the store contents
// RULE13: three 16 bit legacy ports also load and read the store
// RULE14: pattern wake enabled by command bit 3 only, from software
// RULE15: a hit sets the hit flag, which sets wake status, driving wake pin
// RULE16: matching walks from start pointer to last word, unmasked bytes equal
module wpm_store
  import wpm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pattern port registers
  input wire logic port_low_wr,
  input wire logic port_high_wr,
  input wire logic [31:0] port_wdata,
  output logic [31:0] pattern_port_low,
  output logic [31:0] pattern_port_high,
  // legacy 16 bit ports
  input wire logic legacy_wr,
  input wire logic [1:0] legacy_sel,
  input wire logic [15:0] legacy_wdata,
  output logic [15:0] legacy_rdata,
  // wake control and status
  input wire logic cmd_wr,
  input wire logic [15:0] cmd_wdata,
  input wire logic status_clear,
  input wire logic pin_enable,
  output logic pattern_wake_enable,
  output logic pattern_hit_flag,
  output logic wake_event_status,
  output logic wake_pin_b,
  // frame stream
  input wire logic frame_start,
  input wire logic frame_valid,
  input wire logic [31:0] frame_dword
);
  // ************************************************************
  // storage
  // ************************************************************
  logic [STORE_WIDTH-1:0] pattern_store [STORE_DEPTH]; // RULE1
  logic [INDEX_WIDTH-1:0] index;
  logic [23:0] low_latch;
  logic [5:0] m_addr;
  logic [39:0] m_data;
  logic [39:0] entry0;
  logic [39:0] entry1;
  logic hit;
  logic wr_go;
  logic [39:0] wr_word;

  assign wr_go = !pattern_wake_enable && (port_high_wr || (legacy_wr && legacy_sel == LEG_C));
  assign wr_word = port_high_wr ? {port_wdata[HIGH_DATA_MSB:0], low_latch}
                                : {legacy_wdata, low_latch};
  // combinational read: the matcher must see the word it has just moved to,
  // a registered read would hand it the previous word's control byte
  assign m_data = pattern_store[m_addr];

  // ************************************************************
  // index and low data latch
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      index <= 7'h00;
      low_latch <= 24'h000000;
    end else if (!pattern_wake_enable) begin // RULE2
      if (port_low_wr) begin
        index <= port_wdata[LOW_INDEX_MSB:0]; // RULE3 RULE5
        low_latch <= port_wdata[LOW_DATA_MSB:LOW_DATA_LSB]; // RULE3
      end else if (legacy_wr && legacy_sel == LEG_A) begin
        index <= legacy_wdata[LOW_INDEX_MSB:0]; // RULE13
        low_latch[7:0] <= legacy_wdata[15:8];
      end else if (legacy_wr && legacy_sel == LEG_B) begin
        low_latch[23:8] <= legacy_wdata; // RULE13
      end
    end
  end

  // no reset here: contents survive every reset
  always_ff @(posedge clk) begin
    if (wr_go) begin
      pattern_store[index[5:0]] <= wr_word; // RULE4 RULE12
    end
  end

  // ************************************************************
  // read back
  // ************************************************************
  always_ff @(posedge clk) begin
    pattern_port_low <= {pattern_store[index[5:0]][ENTRY_LOW_MSB:0], 8'h00}; // RULE6
    pattern_port_high <= {16'h0000, pattern_store[index[5:0]][ENTRY_HIGH_MSB:ENTRY_HIGH_LSB]};
    entry0 <= pattern_store[ENTRY_PTR_LO];
    entry1 <= pattern_store[ENTRY_PTR_HI];
    unique case (legacy_sel)
      LEG_A: legacy_rdata <= {pattern_store[index[5:0]][7:0], 8'h00} | {8'h00, 1'b0, index};
      LEG_B: legacy_rdata <= pattern_store[index[5:0]][23:8]; // RULE13
      default: legacy_rdata <= pattern_store[index[5:0]][39:24];
    endcase
  end

  // ************************************************************
  // wake control and status
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pattern_wake_enable <= 1'b0;
    end else if (cmd_wr) begin
      pattern_wake_enable <= cmd_wdata[CMD_WAKE_BIT]; // RULE14
    end
  end

  // set wins over clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pattern_hit_flag <= 1'b0;
      wake_event_status <= 1'b0;
    end else begin
      if (hit) begin
        pattern_hit_flag <= 1'b1; // RULE15
      end else if (status_clear) begin
        pattern_hit_flag <= 1'b0;
      end
      if (hit || pattern_hit_flag && !status_clear) begin
        wake_event_status <= 1'b1; // RULE15
      end else if (status_clear) begin
        wake_event_status <= 1'b0;
      end
    end
  end

  assign wake_pin_b = !(wake_event_status && pin_enable); // RULE15

  wpm_matcher u_match (
    .clk(clk),
    .rst_b(rst_b),
    .run(pattern_wake_enable),
    .enables(entry0[7:0]),
    .starts({entry1[39:8], entry0[39:8]}), // RULE8
    .rd_addr(m_addr),
    .rd_data(m_data),
    .frame_start(frame_start),
    .frame_valid(frame_valid),
    .frame_dword(frame_dword),
    .hit(hit)
  );

  // a refused high port commit must leave the addressed word as it was
  property p_write_blocked;
    @(posedge clk) disable iff (!rst_b) (pattern_wake_enable && port_high_wr)
      |=> pattern_store[index[5:0]] == $past(pattern_store[index[5:0]]);
  endproperty
  a_write_blocked: assert property (p_write_blocked) else $error("store write while wake on"); // RULE2
  property p_status_follows_hit;
    @(posedge clk) disable iff (!rst_b) hit |=> pattern_hit_flag && wake_event_status;
  endproperty
  a_status_follows_hit: assert property (p_status_follows_hit) else $error("hit not flagged"); // RULE15
  property p_wake_pin;
    @(posedge clk) disable iff (!rst_b) (wake_event_status && pin_enable) |-> !wake_pin_b;
  endproperty
  a_wake_pin: assert property (p_wake_pin) else $error("wake pin not driven"); // RULE15
  // committed word reads back through both ports two cycles later
  property p_high_read;
    @(posedge clk) disable iff (!rst_b)
      (port_high_wr && !port_low_wr && !pattern_wake_enable)
      |=> ##1 pattern_port_high == {16'h0000, $past(port_wdata[HIGH_DATA_MSB:0], 2)};
  endproperty
  a_high_read: assert property (p_high_read) else $error("high port read wrong"); // RULE6
  property p_low_read;
    @(posedge clk) disable iff (!rst_b)
      (port_high_wr && !port_low_wr && !pattern_wake_enable)
      |=> ##1 pattern_port_low == {$past(low_latch, 2), 8'h00};
  endproperty
  a_low_read: assert property (p_low_read) else $error("low port read wrong"); // RULE6
  property p_index_load;
    @(posedge clk) disable iff (!rst_b)
      (port_low_wr && !pattern_wake_enable) |=> index == $past(port_wdata[6:0]);
  endproperty
  a_index_load: assert property (p_index_load) else $error("index not loaded"); // RULE5
  property p_cmd;
    @(posedge clk) disable iff (!rst_b) cmd_wr |=> pattern_wake_enable == $past(cmd_wdata[3]);
  endproperty
  a_cmd: assert property (p_cmd) else $error("wake enable wrong"); // RULE14
  property p_latch;
    @(posedge clk) disable iff (!rst_b)
      (port_low_wr && !pattern_wake_enable) |=> low_latch == $past(port_wdata[31:8]);
  endproperty
  a_latch: assert property (p_latch) else $error("low data not latched"); // RULE3
endmodule : wpm_store

// >>> test/wpm_store_tb_top.sv
// self-checking bench for the wake pattern match store
`timescale 1ns/1ns
module wpm_store_tb_top;
  import wpm_pkg::*;
  // ************************************************************
  // stimulus and observed signals
  // ************************************************************
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic port_low_wr = 1'b0, port_high_wr = 1'b0, legacy_wr = 1'b0, cmd_wr = 1'b0;
  logic status_clear = 1'b0, pin_enable = 1'b0, frame_start = 1'b0, frame_valid = 1'b0;
  logic [31:0] port_wdata = 32'h0, frame_dword = 32'h0;
  logic [1:0] legacy_sel = LEG_A;
  logic [15:0] legacy_wdata = 16'h0, cmd_wdata = 16'h0;
  logic [31:0] pattern_port_low, pattern_port_high;
  logic [15:0] legacy_rdata;
  logic pattern_wake_enable, pattern_hit_flag, wake_event_status, wake_pin_b;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  wpm_store dut (.clk(clk), .rst_b(rst_b), .port_low_wr(port_low_wr),
    .port_high_wr(port_high_wr), .port_wdata(port_wdata), .pattern_port_low(pattern_port_low),
    .pattern_port_high(pattern_port_high), .legacy_wr(legacy_wr), .legacy_sel(legacy_sel),
    .legacy_wdata(legacy_wdata), .legacy_rdata(legacy_rdata), .cmd_wr(cmd_wr),
    .cmd_wdata(cmd_wdata), .status_clear(status_clear), .pin_enable(pin_enable),
    .pattern_wake_enable(pattern_wake_enable), .pattern_hit_flag(pattern_hit_flag),
    .wake_event_status(wake_event_status), .wake_pin_b(wake_pin_b),
    .frame_start(frame_start), .frame_valid(frame_valid), .frame_dword(frame_dword));
  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic stop_test;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // hang guard, far above the under two hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  // ************************************************************
  // access tasks
  // ************************************************************
  task automatic wr_entry(input logic [6:0] idx, input logic [39:0] d);
    @(posedge clk);
    port_low_wr <= 1'b1;
    port_wdata <= {d[23:0], 1'b0, idx};
    @(posedge clk);
    port_low_wr <= 1'b0;
    port_high_wr <= 1'b1;
    port_wdata <= {16'h0, d[39:24]};
    @(posedge clk);
    port_high_wr <= 1'b0;
  endtask : wr_entry
  // index write carries junk above bit 6, which must be ignored
  task automatic rd_chk(input logic [6:0] idx, input logic [39:0] exp);
    @(posedge clk);
    port_low_wr <= 1'b1;
    port_wdata <= {24'ha5c3e1, 1'b1, idx};
    @(posedge clk);
    port_low_wr <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({pattern_port_high, pattern_port_low}, {16'h0, exp[39:24], exp[23:0], 8'h00});
  endtask : rd_chk
  task automatic lwr(input logic [1:0] sel, input logic [15:0] d);
    @(posedge clk);
    legacy_wr <= 1'b1;
    legacy_sel <= sel;
    legacy_wdata <= d;
    @(posedge clk);
    legacy_wr <= 1'b0;
  endtask : lwr
  task automatic cmd(input logic [15:0] d);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_wr <= 1'b0;
    #1;
    chk(pattern_wake_enable, d[3]);
  endtask : cmd
  task automatic frame(input logic [31:0] d0, input logic [31:0] d1, input logic [2:0] exp);
    @(posedge clk);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    repeat (2) @(posedge clk);
    frame_valid <= 1'b1;
    frame_dword <= d0;
    @(posedge clk);
    frame_dword <= d1;
    @(posedge clk);
    frame_valid <= 1'b0;
    frame_dword <= ~d1;
    repeat (5) @(posedge clk);
    #1;
    chk({pattern_hit_flag, wake_event_status, wake_pin_b}, exp);
  endtask : frame
  task automatic clear_flags;
    @(posedge clk);
    status_clear <= 1'b1;
    @(posedge clk);
    status_clear <= 1'b0;
    #1;
    chk({pattern_hit_flag, wake_event_status, wake_pin_b}, 3'b001);
  endtask : clear_flags
  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    wr_entry(7'h00, 40'h02020202ff);
    wr_entry(7'h01, 40'h0202020200);
    wr_entry(7'h02, 40'h443322118f);
    wr_entry(7'h3f, 40'hfedcba9876);
    rd_chk(7'h00, 40'h02020202ff);
    rd_chk(7'h3f, 40'hfedcba9876);
    // a low write with no high write must leave the entry alone
    @(posedge clk);
    port_low_wr <= 1'b1;
    port_wdata <= 32'h12345602;
    @(posedge clk);
    port_low_wr <= 1'b0;
    rd_chk(7'h02, 40'h443322118f);
    lwr(LEG_A, 16'h5a05);
    lwr(LEG_B, 16'hc3b2);
    lwr(LEG_C, 16'he1d0);
    rd_chk(7'h05, 40'he1d0c3b25a);
    legacy_sel <= LEG_A;
    repeat (3) @(posedge clk);
    #1;
    chk(legacy_rdata, 16'h5a05);
    legacy_sel <= LEG_B;
    repeat (3) @(posedge clk);
    #1;
    chk(legacy_rdata, 16'hc3b2);
    legacy_sel <= LEG_C;
    repeat (3) @(posedge clk);
    #1;
    chk(legacy_rdata, 16'he1d0);
    cmd(16'hfff7);
    cmd(16'h0008);
    pin_enable <= 1'b1;
    frame(32'h44332211, 32'h0, 3'b110);
    wr_entry(7'h02, 40'h0);
    clear_flags();
    frame(32'h44332210, 32'h44332211, 3'b001);
    cmd(16'h0000);
    rd_chk(7'h02, 40'h443322118f);
    wr_entry(7'h02, 40'h777777aa91);
    cmd(16'h0008);
    frame(32'h000000bb, 32'h123456aa, 3'b110);
    pin_enable <= 1'b0;
    @(posedge clk);
    #1;
    chk(wake_pin_b, 1'b1);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk({pattern_wake_enable, pattern_hit_flag, wake_event_status}, 3'b000);
    rd_chk(7'h05, 40'he1d0c3b25a);
    rd_chk(7'h02, 40'h777777aa91);
    wr_entry(7'h00, 40'h0202020200);
    cmd(16'h0008);
    frame(32'h000000bb, 32'h123456aa, 3'b001);
    stop_test();
  end
endmodule : wpm_store_tb_top
